// ### common/drive_status_pkg.sv
// drive status interlock constants: register map, field layout,
// reset values and output terminal function codes.
// assumes 32-bit AXI4-Lite register access, one word per register.
package drive_status_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DETECT_LEVEL = 8'h08;
    localparam logic [7:0] ADDR_RATED_CURRENT = 8'h0c;
    localparam logic [7:0] ADDR_TERM_SEL0 = 8'h10;
    localparam logic [7:0] ADDR_TERM_SEL1 = 8'h14;
    localparam logic [7:0] ADDR_TERM_SEL2 = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_CURRENT = 8'h24;

    // ****************************************
    // field layout
    // ****************************************
    localparam int CTRL_FAULT_RESET_BIT = 0;
    localparam int NUM_TERMS = 3;
    localparam int NUM_FUNCS = 4;
    // status function bit positions
    localparam int FUNC_RUNNING = 0;
    localparam int FUNC_READY = 1;
    localparam int FUNC_CURRENT = 2;
    localparam int FUNC_FAULT = 3;
    // status register: functions in [3:0], terminal levels in [6:4]
    localparam int STAT_TERM_LSB = 4;
    // event bits
    localparam int NUM_EVENTS = 5;
    localparam int EV_FAULT = 0;
    localparam int EV_READY = 1;
    localparam int EV_RUN_START = 2;
    localparam int EV_RUN_STOP = 3;
    localparam int EV_CURRENT = 4;

    localparam int CUR_W = 12;
    localparam int LEVEL_W = 8;
    localparam int CODE_W = 8;
    localparam int PROD_W = 24;
    localparam logic [PROD_W-1:0] PERCENT_SCALE = 24'h000064;

    // ****************************************
    // terminal function codes
    // ****************************************
    localparam logic [CODE_W-1:0] CODE_RUNNING = 8'h00;
    localparam logic [CODE_W-1:0] CODE_READY = 8'h0b;
    localparam logic [CODE_W-1:0] CODE_CURRENT = 8'h0c;
    localparam logic [CODE_W-1:0] CODE_FAULT = 8'h63;
    localparam logic [CODE_W-1:0] CODE_NEG_OFFSET = 8'h64;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [LEVEL_W-1:0] RST_DETECT_LEVEL = 8'h96;
    localparam logic [CUR_W-1:0] RST_RATED_CURRENT = 12'h3e8;
    localparam logic [CODE_W-1:0] RST_TERM_SEL0 = 8'h00;
    localparam logic [CODE_W-1:0] RST_TERM_SEL1 = 8'h0b;
    localparam logic [CODE_W-1:0] RST_TERM_SEL2 = 8'h63;
    localparam logic [NUM_EVENTS-1:0] RST_IRQ_MASK = 5'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MOTOR_STOPPED,
        MOTOR_RUNNING,
        MOTOR_DECEL
    } motor_state_e;

endpackage

// ### rtl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs.
// assumes pins are asynchronous to aclk.
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            level <= '0;
        end else begin
            stage1 <= pin;
            level <= stage1;
        end
    end
endmodule

// ### rtl/term_map.sv
// function selection for one output terminal.
// assumes function levels come from flops on aclk.
`timescale 1ns/10ps
module term_map
    import drive_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_FUNCS-1:0] func_level,
    input wire logic [CODE_W-1:0] code,
    output logic term_out
);
    logic [CODE_W-1:0] base_code;
    logic negative;
    logic known;
    logic sel_level;
    logic next_term_out;

    // codes 100 and up select the inverted function
    assign negative = code >= CODE_NEG_OFFSET;
    assign base_code = negative ? code - CODE_NEG_OFFSET : code;
    assign known = (base_code == CODE_RUNNING) || (base_code == CODE_READY)
        || (base_code == CODE_CURRENT) || (base_code == CODE_FAULT);
    assign sel_level = (base_code == CODE_RUNNING) ? func_level[FUNC_RUNNING]
        : (base_code == CODE_READY) ? func_level[FUNC_READY]
        : (base_code == CODE_CURRENT) ? func_level[FUNC_CURRENT]
        : func_level[FUNC_FAULT];
    // unknown codes leave the terminal off
    assign next_term_out = known & (sel_level ^ negative);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_out <= 1'b0;
        end else begin
            term_out <= next_term_out;
        end
    end
endmodule

// ### rtl/drive_status_interlock.sv
// drive status outputs: fault, ready, running, current detection,
// three assignable output terminals and the relay contact group.
// assumes an AXI4-Lite master on aclk; start, fault trip and power
// pins are asynchronous; motor current and output-stopped come from
// the modulator on aclk.
`timescale 1ns/10ps
module drive_status_interlock
    import drive_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // drive side
    input wire logic forward_start_input,
    input wire logic reverse_start_input,
    input wire logic fault_trip,
    input wire logic power_good,
    input wire logic output_stopped,
    input wire logic [CUR_W-1:0] motor_current,
    // status outputs
    output logic fault_output,
    output logic operation_ready_output,
    output logic running_output,
    output logic current_detect_output,
    output logic [NUM_TERMS-1:0] term_out,
    output logic relay_contact_no,
    output logic relay_contact_nc,
    output logic irq
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] pin_level;
    logic fwd_sync;
    logic rev_sync;
    logic trip_sync;
    logic power_sync;

    pin_sync #(.WIDTH(4)) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin({power_good, fault_trip, reverse_start_input,
            forward_start_input}),
        .level(pin_level)
    );
    assign fwd_sync = pin_level[0];
    assign rev_sync = pin_level[1];
    assign trip_sync = pin_level[2];
    assign power_sync = pin_level[3];

    // ****************************************
    // registers
    // ****************************************
    logic fault_latched;
    logic [LEVEL_W-1:0] detect_level;
    logic [CUR_W-1:0] rated_current;
    logic [CODE_W-1:0] term_sel [NUM_TERMS];
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    motor_state_e motor_state;
    motor_state_e next_motor_state;
    logic [NUM_FUNCS-1:0] func_level;
    logic [NUM_FUNCS-1:0] func_prev;

    // ****************************************
    // axi write channel
    // ****************************************
    logic wr_take;
    logic [7:0] wr_addr;
    logic wr_hit_ctrl;
    logic wr_hit_level;
    logic wr_hit_rated;
    logic wr_hit_irq;
    logic wr_hit_mask;
    logic [NUM_TERMS-1:0] wr_hit_sel;
    logic wr_mapped;
    logic fault_reset;

    assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign wr_addr = s_axi_awaddr;
    assign wr_hit_ctrl = wr_take && wr_addr == ADDR_CONTROL;
    assign wr_hit_level = wr_take && wr_addr == ADDR_DETECT_LEVEL;
    assign wr_hit_rated = wr_take && wr_addr == ADDR_RATED_CURRENT;
    assign wr_hit_sel[0] = wr_take && wr_addr == ADDR_TERM_SEL0;
    assign wr_hit_sel[1] = wr_take && wr_addr == ADDR_TERM_SEL1;
    assign wr_hit_sel[2] = wr_take && wr_addr == ADDR_TERM_SEL2;
    assign wr_hit_irq = wr_take && wr_addr == ADDR_IRQ_STATUS;
    assign wr_hit_mask = wr_take && wr_addr == ADDR_IRQ_MASK;
    assign wr_mapped = wr_hit_ctrl | wr_hit_level | wr_hit_rated
        | (|wr_hit_sel) | wr_hit_irq | wr_hit_mask
        | (wr_addr == ADDR_STATUS) | (wr_addr == ADDR_CURRENT);
    assign fault_reset = wr_hit_ctrl & s_axi_wstrb[0]
        & s_axi_wdata[CTRL_FAULT_RESET_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            detect_level <= RST_DETECT_LEVEL;
        end else if (wr_hit_level && s_axi_wstrb[0]) begin
            detect_level <= s_axi_wdata[LEVEL_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rated_current <= RST_RATED_CURRENT;
        end else if (wr_hit_rated) begin
            if (s_axi_wstrb[0]) begin
                rated_current[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
                rated_current[CUR_W-1:8] <= s_axi_wdata[CUR_W-1:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_sel[0] <= RST_TERM_SEL0;
            term_sel[1] <= RST_TERM_SEL1;
            term_sel[2] <= RST_TERM_SEL2;
        end else begin
            for (int i = 0; i < NUM_TERMS; i++) begin
                if (wr_hit_sel[i] && s_axi_wstrb[0]) begin
                    term_sel[i] <= s_axi_wdata[CODE_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= RST_IRQ_MASK;
        end else if (wr_hit_mask && s_axi_wstrb[0]) begin
            irq_mask <= s_axi_wdata[NUM_EVENTS-1:0];
        end
    end

    // ****************************************
    // fault, ready, running
    // ****************************************
    logic start_cmd;
    logic [PROD_W-1:0] current_scaled;
    logic [PROD_W-1:0] threshold;
    logic over_level;

    assign start_cmd = fwd_sync | rev_sync;

    // a trip wins over a reset written in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_latched <= 1'b0;
        end else if (trip_sync) begin
            fault_latched <= 1'b1;
        end else if (fault_reset) begin
            fault_latched <= 1'b0;
        end
    end

    always_comb begin
        next_motor_state = motor_state;
        unique case (motor_state)
            MOTOR_STOPPED: begin
                if (start_cmd && func_level[FUNC_READY]) begin
                    next_motor_state = MOTOR_RUNNING;
                end
            end
            MOTOR_RUNNING: begin
                if (fault_latched) begin
                    next_motor_state = MOTOR_STOPPED;
                end else if (!start_cmd) begin
                    next_motor_state = MOTOR_DECEL;
                end
            end
            MOTOR_DECEL: begin
                if (fault_latched || output_stopped) begin
                    next_motor_state = MOTOR_STOPPED;
                end else if (start_cmd) begin
                    next_motor_state = MOTOR_RUNNING;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            motor_state <= MOTOR_STOPPED;
        end else begin
            motor_state <= next_motor_state;
        end
    end

    // compare current*100 against level percent of rated current
    assign current_scaled = PROD_W'(motor_current) * PERCENT_SCALE;
    assign threshold = PROD_W'(detect_level) * PROD_W'(rated_current);
    assign over_level = current_scaled > threshold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_level <= '0;
            func_prev <= '0;
        end else begin
            func_level[FUNC_FAULT] <= fault_latched;
            func_level[FUNC_READY] <= power_sync & ~fault_latched;
            func_level[FUNC_RUNNING] <= motor_state != MOTOR_STOPPED;
            func_level[FUNC_CURRENT] <= (motor_state != MOTOR_STOPPED)
                & over_level;
            func_prev <= func_level;
        end
    end

    assign fault_output = func_level[FUNC_FAULT];
    assign operation_ready_output = func_level[FUNC_READY];
    assign running_output = func_level[FUNC_RUNNING];
    assign current_detect_output = func_level[FUNC_CURRENT];

    // ****************************************
    // output terminals
    // ****************************************
    for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
        term_map u_term_map (
            .aclk(aclk),
            .aresetn(aresetn),
            .func_level(func_level),
            .code(term_sel[t]),
            .term_out(term_out[t])
        );
    end

    // relay group follows terminal 2: b-c opens when active
    assign relay_contact_no = term_out[2];
    assign relay_contact_nc = ~term_out[2];

    // ****************************************
    // interrupts
    // ****************************************
    logic [NUM_EVENTS-1:0] event_set;
    logic [NUM_EVENTS-1:0] irq_clear;

    assign event_set[EV_FAULT] = func_level[FUNC_FAULT]
        & ~func_prev[FUNC_FAULT];
    assign event_set[EV_READY] = func_level[FUNC_READY]
        & ~func_prev[FUNC_READY];
    assign event_set[EV_RUN_START] = func_level[FUNC_RUNNING]
        & ~func_prev[FUNC_RUNNING];
    assign event_set[EV_RUN_STOP] = ~func_level[FUNC_RUNNING]
        & func_prev[FUNC_RUNNING];
    assign event_set[EV_CURRENT] = func_level[FUNC_CURRENT]
        & ~func_prev[FUNC_CURRENT];
    assign irq_clear = (wr_hit_irq && s_axi_wstrb[0])
        ? s_axi_wdata[NUM_EVENTS-1:0] : '0;

    // a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | event_set;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ****************************************
    // axi read channel
    // ****************************************
    logic rd_take;
    logic [31:0] rd_word;
    logic rd_mapped;

    assign rd_take = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_take;

    always_comb begin
        rd_word = 32'h00000000;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr)
            ADDR_CONTROL: rd_word = 32'h00000000;
            ADDR_STATUS: begin
                rd_word[NUM_FUNCS-1:0] = func_level;
                rd_word[STAT_TERM_LSB+:NUM_TERMS] = term_out;
            end
            ADDR_DETECT_LEVEL: rd_word[LEVEL_W-1:0] = detect_level;
            ADDR_RATED_CURRENT: rd_word[CUR_W-1:0] = rated_current;
            ADDR_TERM_SEL0: rd_word[CODE_W-1:0] = term_sel[0];
            ADDR_TERM_SEL1: rd_word[CODE_W-1:0] = term_sel[1];
            ADDR_TERM_SEL2: rd_word[CODE_W-1:0] = term_sel[2];
            ADDR_IRQ_STATUS: rd_word[NUM_EVENTS-1:0] = irq_status;
            ADDR_IRQ_MASK: rd_word[NUM_EVENTS-1:0] = irq_mask;
            ADDR_CURRENT: rd_word[CUR_W-1:0] = motor_current;
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ### test/drive_status_assertions.sv
// checker: bus handshake and status output timing of the drive block.
// assumes it is bound into drive_status_interlock, one clock aclk.
`timescale 1ns/10ps
module drive_status_assertions
    import drive_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic forward_start_input,
    input wire logic fault_trip,
    input wire logic power_good,
    input wire logic output_stopped,
    input wire logic fault_output,
    input wire logic operation_ready_output,
    input wire logic running_output,
    input wire logic current_detect_output,
    input wire logic [NUM_TERMS-1:0] term_out,
    input wire logic relay_contact_no,
    input wire logic relay_contact_nc
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // start pin held with the drive able to run, long enough to sync
    sequence start_held;
        (forward_start_input && power_good && !fault_trip
            && operation_ready_output)[*5];
    endsequence
    sequence trip_held;
        fault_trip[*5];
    endsequence

    wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write response missing");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    fault_set_a: assert property (trip_held |-> fault_output)
        else $error("fault output late");
    relay_pair_a: assert property (relay_contact_no == term_out[2]
        && relay_contact_nc != relay_contact_no)
        else $error("relay contacts wrong");
    ready_fault_a: assert property (fault_output
        && $past(fault_output) |-> !operation_ready_output)
        else $error("ready while faulted");
    run_start_a: assert property (start_held |-> running_output)
        else $error("running output late");
    run_stop_a: assert property ($fell(running_output)
        |-> $past(output_stopped, 2) || fault_output)
        else $error("running ended before stop");
    cur_run_a: assert property (current_detect_output
        |-> running_output || $past(running_output))
        else $error("current detect while stopped");
endmodule

bind drive_status_interlock drive_status_assertions
    u_drive_status_assertions (.*);

// ### test/interlock_model.sv
// model of the external interlock controller watching drive status.
// assumes status outputs and start pins settle on aclk.
`timescale 1ns/10ps
module interlock_model #(
    parameter int ALLOW = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic fault,
    input wire logic ready,
    input wire logic running,
    input wire logic cur_det,
    input wire logic cur_nonzero,
    output logic alarm
);
    // ****************************************
    // mismatch check
    // ****************************************
    logic [7:0] cnt;
    logic bad;

    assign bad = (start && !fault && !running)
        || (!start && running)
        || (start && running && !cur_det)
        || (!fault && !ready)
        || (start && running && !cur_nonzero)
        || (!start && !running && cur_nonzero);

    // decel allowance: only a lasting mismatch counts
    always_ff @(posedge aclk) begin
        if (!aresetn || !bad) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
    end
    assign alarm = cnt > ALLOW;
endmodule

// ### test/drive_status_interlock_tb.sv
// testbench: bus master, pin stimulus, queued bus checks.
// assumes the package, design, checker and interlock model.
`timescale 1ns/10ps
module drive_status_interlock_tb
    import drive_status_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic forward_start_input = 1'b0, reverse_start_input = 1'b0;
    logic fault_trip = 1'b0, power_good = 1'b1, output_stopped = 1'b0;
    logic [CUR_W-1:0] motor_current = 12'h000;
    logic fault_output, operation_ready_output, running_output;
    logic current_detect_output, relay_contact_no, relay_contact_nc;
    logic irq, alarm;
    logic [NUM_TERMS-1:0] term_out;
    logic [34:0] exp_q [$];
    logic [31:0] rst_val [10] = '{32'h0, 32'h22, 32'h96, 32'h3e8, 32'h0,
        32'h0b, 32'h63, 32'h02, 32'h0, 32'h0};
    logic [7:0] codes [9] = '{8'h00, 8'h0b, 8'h0c, 8'h63, 8'h64, 8'h6f,
        8'h70, 8'hc7, 8'h05};
    logic [8:0] term_exp = 9'h087;
    int err_total = 0, tests_run = 0, cycles = 0;
    int unsigned seed, lvl, cur;

    always #2.5 aclk = ~aclk;

    drive_status_interlock u_drive_status_interlock (.*);

    interlock_model #(.ALLOW(40)) u_interlock_model (
        .aclk(aclk), .aresetn(aresetn),
        .start(forward_start_input | reverse_start_input),
        .fault(fault_output), .ready(operation_ready_output),
        .running(running_output), .cur_det(current_detect_output),
        .cur_nonzero(|motor_current), .alarm(alarm));

    // ****************************************
    // checks and bus tasks
    // ****************************************
    task automatic stop_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_pin(input logic [31:0] got, input logic [31:0] e);
        tests_run++;
        if (got !== e) begin
            err_total++;
            $display("Error %0t: pin %h expected %h", $time, got, e);
        end
    endtask

    // top bit of e: response only, data not compared (set for every write and for slave-error reads)
    task automatic check_bus(input logic [33:0] got, input logic [34:0] e);
        tests_run++;
        if (e[34] ? got[33:32] !== e[33:32] : got !== e[33:0]) begin
            err_total++;
            $display("Error %0t: bus %h expected %h", $time, got, e);
        end
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (s_axi_rvalid && s_axi_rready) begin
            check_bus({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) begin
            check_bus({s_axi_bresp, 32'h0}, exp_q.pop_front());
        end
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({1'b1, r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r == RESP_SLVERR, r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = $urandom(92);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            rd(8'(4 * i), rst_val[i]);
        end
        rd(8'h28, 32'h0, RESP_SLVERR);
        wr(8'h28, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hff);
        check_pin(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h2);
        check_pin(irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h2);
        check_pin(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h1);
        motor_current <= 12'hfff;
        for (int d = 0; d < 2; d++) begin
            forward_start_input <= (d == 0);
            reverse_start_input <= (d == 1);
            repeat (6) @(posedge aclk);
            check_pin(running_output, 1'b1);
            check_pin(current_detect_output, 1'b1);
            check_pin(alarm, 1'b0);
            forward_start_input <= 1'b0;
            reverse_start_input <= 1'b0;
            repeat (8) @(posedge aclk);
            check_pin(running_output, 1'b1);
            check_pin(current_detect_output, 1'b1);
            output_stopped <= 1'b1;
            repeat (4) @(posedge aclk);
            check_pin(running_output, 1'b0);
            check_pin(current_detect_output, 1'b0);
            output_stopped <= 1'b0;
        end
        forward_start_input <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            lvl = (k < 4) ? 150 : 20;
            cur = (k % 4 < 2) ? lvl * 10 + k % 2 : $urandom % 4096;
            if (k % 4 == 0) begin
                wr(ADDR_DETECT_LEVEL, lvl);
            end
            motor_current <= cur[11:0];
            repeat (3) @(posedge aclk);
            check_pin(current_detect_output, cur * 100 > lvl * 1000);
        end
        rd(ADDR_CURRENT, cur);
        motor_current <= 12'hfff;
        for (int k = 0; k < 9; k++) begin
            for (int t = 0; t < 3; t++) begin
                wr(8'(ADDR_TERM_SEL0 + 4 * t), codes[k]);
            end
            repeat (2) @(posedge aclk);
            check_pin(term_out, {3{term_exp[k]}});
        end
        wr(ADDR_TERM_SEL2, 32'h63);
        motor_current <= 12'h000;
        repeat (50) @(posedge aclk);
        check_pin(alarm, 1'b1);
        motor_current <= 12'hfff;
        repeat (3) @(posedge aclk);
        check_pin(alarm, 1'b0);
        fault_trip <= 1'b1;
        repeat (6) @(posedge aclk);
        check_pin({fault_output, relay_contact_no, relay_contact_nc,
            running_output, operation_ready_output, irq}, 6'h31);
        fault_trip <= 1'b0;
        forward_start_input <= 1'b0;
        repeat (6) @(posedge aclk);
        check_pin(fault_output, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        check_pin(irq, 1'b0);
        wr(ADDR_CONTROL, 32'h1);
        repeat (4) @(posedge aclk);
        check_pin({fault_output, operation_ready_output}, 2'h1);
        wr(ADDR_TERM_SEL2, 32'hc7);
        repeat (2) @(posedge aclk);
        check_pin(term_out[2], 1'b1);
        fault_trip <= 1'b1;
        repeat (6) @(posedge aclk);
        check_pin({term_out[2], relay_contact_nc}, 2'h1);
        fault_trip <= 1'b0;
        stop_test();
    end
endmodule
